//--- dps_pkg.sv
// Shared constants and types for the semaphore port controller
`default_nettype none

package dps_pkg;

    // ========================================
    // Pin and latch geometry
    localparam int DATA_W      = 8;  // Width of the port data bus
    localparam int LATCH_CNT   = 8;  // Semaphore latches in the device
    localparam int LATCH_AW    = 3;  // Low address bits that pick a latch
    localparam int SYNC_STAGES = 2;  // Flops on the returning data pins

    // ========================================
    // Timing, in ns as the device needs them, and derived cycle counts
    localparam int CLK_MHZ     = 50;
    localparam int T_WRITE_NS  = 40; // Least write-enable low time
    localparam int T_ACCESS_NS = 60; // Longest select/enable to data valid
    localparam int T_GAP_NS    = 20; // Least select-high time between reads
    localparam int WRITE_CYC   = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC  = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC     = (T_GAP_NS * CLK_MHZ + 999) / 1000;

    // ========================================
    // Token encoding on data bit zero: low requests or holds, high frees
    localparam logic TOKEN_REQUEST = 1'b0;
    localparam logic TOKEN_RELEASE = 1'b1;

    // ========================================
    // Reset values of the pins (everything idle, bus not driven)
    localparam logic [LATCH_AW-1:0] ADDR_RESET = 3'h0;
    localparam logic [DATA_W-1:0]   DOUT_RESET = 8'h00;

    // Operations offered on the user command port
    typedef enum logic [1:0] {
        DPS_OP_ACQUIRE = 2'b00,
        DPS_OP_RELEASE = 2'b01,
        DPS_OP_TEST    = 2'b10
    } dps_op_t;

    // One user command
    typedef struct packed {
        dps_op_t               op;
        logic [LATCH_AW-1:0]   latch;
    } dps_cmd_t;

    // Pins driven towards the device port
    typedef struct packed {
        logic                  semaphore_select_n;
        logic                  write_enable_n;
        logic                  output_enable_n;
        logic [LATCH_AW-1:0]   addr;
        logic [DATA_W-1:0]     data_out;
        logic                  data_oe;
    } dps_pins_t;

endpackage

`default_nettype wire

//--- dps_sync.sv
// Two-flop synchroniser for the data pins returning from the device
`default_nettype none

module dps_sync
    import dps_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic             clk,      // System clock
    input  wire logic             rst_n,    // Asynchronous reset, active low
    input  wire logic             ce,       // Clock enable
    input  wire logic [WIDTH-1:0] d_async,  // Pin level, unsynchronised
    output logic      [WIDTH-1:0] q_sync    // Level after two flops
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // ========================================
    // Next values: first stage feeds only the second
    always_comb begin
        meta_next = ce ? d_async : meta_reg;
        sync_next = ce ? meta_reg : sync_reg;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_sync = sync_reg;

endmodule

`default_nettype wire

//--- dps_sem_host.sv
// Controller driving one port of a dual-port semaphore latch bank
`default_nettype none

// How it works
// - write asserts select, write enable, data bit
// - select dropped and reasserted between polling reads
// - write zero requests, write one releases
// - denied acquire retests until grant read
module dps_sem_host
    import dps_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic              clk,          // System clock, 50 MHz
    input  wire logic              rst_n,        // Asynchronous reset, active low
    input  wire logic              ce,           // Clock enable, freezes all state
    input  wire logic              cmd_valid,    // Command offered
    input  wire dps_cmd_t          cmd,          // Operation and latch index
    output logic                   cmd_ready,    // Controller idle, takes command
    output logic                   rsp_valid,    // Command finished, one cycle
    output logic                   rsp_granted,  // Token held after the command
    output logic                   rsp_mixed,    // Read data lines disagreed
    output dps_pins_t              pins,         // Pins towards the device port
    input  wire logic [DATA_W-1:0] data_in       // Data pins from the device
);

    // ========================================
    // Elaboration checks
    // Zero-length counts would wrap the down-counter loads
    if (CNT_W < 2 || (ACCESS_CYC + SYNC_STAGES) >= (1 << CNT_W) ||
        WRITE_CYC < 1 || GAP_CYC < 1 ||
        WRITE_CYC >= (1 << CNT_W) || GAP_CYC >= (1 << CNT_W) ||
        LATCH_CNT != (1 << LATCH_AW)) begin : g_bad_params
        $error("dps_sem_host: counter too narrow or latch geometry wrong");
    end

    localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYC - 1);
    localparam logic [CNT_W-1:0] READ_LOAD  = CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
    localparam logic [CNT_W-1:0] GAP_LOAD   = CNT_W'(GAP_CYC - 1);

    typedef enum logic [2:0] {
        DPS_ST_IDLE     = 3'b000,
        DPS_ST_WR_SETUP = 3'b001,
        DPS_ST_WR_PULSE = 3'b010,
        DPS_ST_WR_HOLD  = 3'b011,
        DPS_ST_RD_GAP   = 3'b100,
        DPS_ST_RD_ON    = 3'b101
    } dps_state_t;

    // All eight lines equal means a clean latch read
    function automatic logic lines_agree(input logic [DATA_W-1:0] d);
        lines_agree = (d == {DATA_W{1'b0}}) || (d == {DATA_W{1'b1}});
    endfunction

    dps_state_t          state_reg, state_next;
    dps_op_t             op_reg, op_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    dps_pins_t           pins_reg, pins_next;
    logic                ready_reg, ready_next;
    logic                rsp_valid_reg, rsp_valid_next;
    logic                granted_reg, granted_next;
    logic                mixed_reg, mixed_next;
    logic [DATA_W-1:0]   data_sync;

    // ========================================
    // Data pins cross into the clock domain
    dps_sync #(
        .WIDTH (DATA_W)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .d_async (data_in),
        .q_sync  (data_sync)
    );

    // ========================================
    // Port sequencer: next values
    always_comb begin
        state_next     = state_reg;
        op_next        = op_reg;
        cnt_next       = cnt_reg;
        pins_next      = pins_reg;
        granted_next   = granted_reg;
        mixed_next     = mixed_reg;
        rsp_valid_next = ce ? 1'b0 : rsp_valid_reg;  // Pulse frozen while disabled
        if (ce) begin
            case (state_reg)
                DPS_ST_IDLE: begin
                    if (cmd_valid) begin
                        op_next        = cmd.op;
                        pins_next.addr = cmd.latch;
                        mixed_next     = 1'b0;
                        if (cmd.op == DPS_OP_TEST) begin
                            pins_next.semaphore_select_n = 1'b0;
                            pins_next.output_enable_n    = 1'b0;
                            cnt_next   = READ_LOAD;
                            state_next = DPS_ST_RD_ON;
                        end else begin
                            // Request drives zero, release drives one on every line
                            pins_next.data_out = {DATA_W{(cmd.op == DPS_OP_RELEASE) ?
                                                 TOKEN_RELEASE : TOKEN_REQUEST}};
                            pins_next.data_oe            = 1'b1;
                            pins_next.semaphore_select_n = 1'b0;
                            state_next = DPS_ST_WR_SETUP;
                        end
                    end
                end
                DPS_ST_WR_SETUP: begin
                    pins_next.write_enable_n = 1'b0;
                    cnt_next   = WRITE_LOAD;
                    state_next = DPS_ST_WR_PULSE;
                end
                DPS_ST_WR_PULSE: begin
                    if (cnt_reg == '0) begin
                        pins_next.write_enable_n = 1'b1;
                        state_next = DPS_ST_WR_HOLD;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                DPS_ST_WR_HOLD: begin
                    // Data held one cycle past write enable, then bus let go
                    pins_next.semaphore_select_n = 1'b1;
                    pins_next.data_oe            = 1'b0;
                    if (op_reg == DPS_OP_ACQUIRE) begin
                        cnt_next   = GAP_LOAD;
                        state_next = DPS_ST_RD_GAP;
                    end else begin
                        granted_next   = 1'b0;
                        rsp_valid_next = 1'b1;
                        state_next     = DPS_ST_IDLE;
                    end
                end
                DPS_ST_RD_GAP: begin
                    // Select stays high so the device reopens its read hold
                    if (cnt_reg == '0) begin
                        pins_next.semaphore_select_n = 1'b0;
                        pins_next.output_enable_n    = 1'b0;
                        cnt_next   = READ_LOAD;
                        state_next = DPS_ST_RD_ON;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                DPS_ST_RD_ON: begin
                    if (cnt_reg == '0) begin
                        pins_next.semaphore_select_n = 1'b1;
                        pins_next.output_enable_n    = 1'b1;
                        mixed_next = mixed_reg | ~lines_agree(data_sync);
                        if (op_reg == DPS_OP_ACQUIRE &&
                            data_sync[0] == TOKEN_RELEASE) begin
                            cnt_next   = GAP_LOAD;
                            state_next = DPS_ST_RD_GAP;
                        end else begin
                            granted_next   = (data_sync[0] == TOKEN_REQUEST);
                            rsp_valid_next = 1'b1;
                            state_next     = DPS_ST_IDLE;
                        end
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                default: begin
                    pins_next.semaphore_select_n = 1'b1;
                    pins_next.write_enable_n     = 1'b1;
                    pins_next.output_enable_n    = 1'b1;
                    pins_next.data_oe            = 1'b0;
                    state_next = DPS_ST_IDLE;
                end
            endcase
        end
        ready_next = ce ? (state_next == DPS_ST_IDLE) : ready_reg;
    end

    // Port sequencer: registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg                   <= DPS_ST_IDLE;
            op_reg                      <= DPS_OP_TEST;
            cnt_reg                     <= '0;
            pins_reg.semaphore_select_n <= 1'b1;
            pins_reg.write_enable_n     <= 1'b1;
            pins_reg.output_enable_n    <= 1'b1;
            pins_reg.addr               <= ADDR_RESET;
            pins_reg.data_out           <= DOUT_RESET;
            pins_reg.data_oe            <= 1'b0;
            ready_reg                   <= 1'b1;
            rsp_valid_reg               <= 1'b0;
            granted_reg                 <= 1'b0;
            mixed_reg                   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            op_reg        <= op_next;
            cnt_reg       <= cnt_next;
            pins_reg      <= pins_next;
            ready_reg     <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            granted_reg   <= granted_next;
            mixed_reg     <= mixed_next;
        end
    end

    // Outputs straight from flops
    assign cmd_ready   = ready_reg;
    assign rsp_valid   = rsp_valid_reg;
    assign rsp_granted = granted_reg;
    assign rsp_mixed   = mixed_reg;
    assign pins        = pins_reg;

endmodule

`default_nettype wire

//--- dps_sem_checker.sv
// Protocol checker for the semaphore port controller
`default_nettype none
module dps_sem_checker
    import dps_pkg::*;
(
    input wire logic              clk,         // Clock
    input wire logic              rst_n,       // Reset
    input wire logic              ce,          // Enable
    input wire logic              cmd_valid,   // Offer
    input wire dps_cmd_t          cmd,         // Command
    input wire logic              cmd_ready,   // Idle
    input wire logic              rsp_valid,   // Done
    input wire logic              rsp_granted, // Held
    input wire logic              rsp_mixed,   // Mixed
    input wire dps_pins_t         pins,        // Pins
    input wire logic [DATA_W-1:0] data_in      // Data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Strobes
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic sel, wr, rd, take;
    assign sel  = !pins.semaphore_select_n;
    assign wr   = !pins.write_enable_n;
    assign rd   = sel && !pins.output_enable_n;
    assign take = ce && cmd_valid && cmd_ready;
    // ====
    // Write pulse and release ending
    sequence s_pulse;
        wr [*2] ##1 !wr;
    endsequence
    sequence s_rel_end;
        s_pulse ##1 (rsp_valid && !rsp_granted && !sel);
    endsequence
    AST_WR_SEL: assert property (wr |-> sel)
        else $error("write outside select");
    AST_WR_DATA: assert property (wr |-> pins.data_oe
        && pins.data_out inside {8'hFF, 8'h00}) else $error("bad write data");
    AST_RD_FREE: assert property (rd |-> !wr && !pins.data_oe)
        else $error("bus driven in read");
    AST_REL: assert property (take && cmd.op == DPS_OP_RELEASE |=> sel && !wr
        && pins.data_out == 8'hFF && pins.addr == $past(cmd.latch) ##1 s_rel_end)
        else $error("release walk wrong");
    AST_ACQ: assert property (take && cmd.op == DPS_OP_ACQUIRE |=> sel
        && pins.data_out == 8'h00 ##1 s_pulse) else $error("request walk wrong");
    AST_TEST: assert property (take && cmd.op == DPS_OP_TEST |=> rd ##[4:5] rsp_valid)
        else $error("test walk wrong");
    AST_RD_LEN: assert property ($rose(rd) |-> rd [*5] ##1 !rd)
        else $error("read not cyclic");
    AST_IDLE: assert property (cmd_ready |-> !sel && !wr && !pins.data_oe)
        else $error("pins busy while idle");
endmodule
bind dps_sem_host dps_sem_checker u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted),
    .rsp_mixed(rsp_mixed), .pins(pins), .data_in(data_in));
`default_nettype wire

//--- dps_dev_model.sv
// Semaphore latch bank model: port A on pins, port B by tasks
`default_nettype none
module dps_dev_model
    import dps_pkg::*;
(
    input  wire dps_pins_t         pins,      // Port A pins
    input  wire logic              bad_lines, // Spoil top line
    output logic      [DATA_W-1:0] data_in    // Port A data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Owner 0 free, 1 port A, 2 port B; no memory array
    logic [1:0]        own [LATCH_CNT] = '{default: 2'h0};
    logic              req [2][LATCH_CNT] = '{default: 1'b0};
    logic              frz = 1'b1;
    logic              rd;
    logic [DATA_W-1:0] word = 8'h00;
    // Request or release; arbiter moves the token
    task automatic apply(input int p, input int k, input logic v);
        req[p][k] = (v == TOKEN_REQUEST);
        if (v == TOKEN_REQUEST && own[k] == 2'h0) own[k] = 2'(p + 1);
        else if (v == TOKEN_RELEASE && own[k] == 2'(p + 1))
            own[k] = req[1 - p][k] ? 2'(2 - p) : 2'h0;
    endtask
    task automatic b_write(input int k, input logic v);
        apply(1, k, v);
    endtask
    function automatic logic [7:0] b_read(input int k);
        return {8{own[k] != 2'h2}};
    endfunction
    // Port A write taken as the strobe ends
    always @(posedge pins.write_enable_n) begin
        if (!pins.semaphore_select_n) begin
            apply(0, pins.addr, pins.data_out[0]);
        end
    end
    // Frozen read; released lines show the inverse
    assign rd = !pins.semaphore_select_n && !pins.output_enable_n && pins.write_enable_n;
    always @(posedge rd) frz = (own[pins.addr] != 2'h1);
    always @* if (rd) word = {frz ^ bad_lines, {7{frz}}};
    assign data_in = rd ? word : ~word;
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the semaphore port controller
`default_nettype none
module testbench;
    import dps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals, controller and device
    logic              clk, rst_n, ce, cmd_valid, bad, g, m, ok;
    logic              cmd_ready, rsp_valid, rsp_granted, rsp_mixed;
    dps_cmd_t          cmd;
    dps_pins_t         pins;
    logic [DATA_W-1:0] data_in;
    int                fail_count = 0;
    int                n_checks = 0;
    dps_sem_host u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted),
        .rsp_mixed(rsp_mixed), .pins(pins), .data_in(data_in));
    dps_dev_model u_dev (.pins(pins), .bad_lines(bad), .data_in(data_in));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ====
    // Shared tasks
    task automatic stop_test;
        $display("TB: checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] exp, input logic [7:0] act);
        n_checks++;
        if (act !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic flag(input logic exp, input logic act);
        check({7'h0, exp}, {7'h0, act});
    endtask
    // One command, response awaited for at most lim cycles
    task automatic run(input dps_op_t op, input int k, input int lim);
        ok = 1'b0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{op: op, latch: k[2:0]};
        @(negedge clk);
        cmd_valid = 1'b0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(negedge clk);
            ok = rsp_valid;
        end
        g = rsp_granted;
        m = rsp_mixed;
        if (ok !== 1'b1) begin
            flag(1'b1, ok);
            stop_test();
        end
    endtask
    // ====
    // Scenarios
    task automatic t_init;
        for (int k = 0; k < LATCH_CNT; k++) begin
            run(DPS_OP_TEST, k, 20);
            flag(1'b0, g);
            u_dev.b_write(k, TOKEN_REQUEST);
            check(8'h00, u_dev.b_read(k));
            u_dev.b_write(k, TOKEN_RELEASE);
        end
    endtask
    task automatic t_own;
        run(DPS_OP_ACQUIRE, 3, 40);
        flag(1'b1, g);
        u_dev.b_write(3, TOKEN_REQUEST);
        check(8'hFF, u_dev.b_read(3));
        run(DPS_OP_RELEASE, 3, 20);
        check(8'h00, u_dev.b_read(3));
        run(DPS_OP_TEST, 3, 20);
        flag(1'b0, g);
        u_dev.b_write(3, TOKEN_RELEASE);
    endtask
    task automatic t_pend;
        u_dev.b_write(5, TOKEN_REQUEST);
        fork
            run(DPS_OP_ACQUIRE, 5, 300);
            begin
                repeat (40) @(negedge clk);
                flag(1'b0, cmd_ready);
                u_dev.b_write(5, TOKEN_RELEASE);
            end
        join
        flag(1'b1, g);
        run(DPS_OP_RELEASE, 5, 20);
        check(8'hFF, u_dev.b_read(5));
    endtask
    task automatic t_race;
        logic b;
        fork
            run(DPS_OP_ACQUIRE, 7, 300);
            begin
                @(negedge clk);
                repeat (WRITE_CYC + 2) @(posedge clk);
                u_dev.b_write(7, TOKEN_REQUEST);
                b = (u_dev.b_read(7) == 8'h00);
                repeat (30) @(negedge clk);
                flag(b, !cmd_ready);
                u_dev.b_write(7, TOKEN_RELEASE);
            end
        join
        flag(1'b1, g);
        run(DPS_OP_RELEASE, 7, 20);
    endtask
    task automatic t_misc;
        bad = 1'b1;
        run(DPS_OP_TEST, 0, 20);
        flag(1'b1, m);
        bad = 1'b0;
        run(DPS_OP_TEST, 0, 20);
        flag(1'b0, m);
        ce = 1'b0;
        cmd_valid = 1'b1;
        repeat (5) @(negedge clk);
        flag(1'b1, pins.semaphore_select_n);
        cmd_valid = 1'b0;
        ce = 1'b1;
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        bad = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(8'h02, {6'h0, pins.semaphore_select_n, pins.data_oe});
        rst_n = 1'b1;
        t_init();
        t_own();
        t_pend();
        t_race();
        t_misc();
        stop_test();
    end
endmodule
`default_nettype wire
